// [design/vcs_pkg.sv]
// Shared constants and carriers for the capture sync control block.
// Assumes a classic Wishbone master with 32-bit data and a byte-wide video source.
package vcs_pkg;

    // Register byte offsets
    localparam logic [3:0]  VCS_OFS_CTRL      = 4'h0;   // capture_channel_a_control
    localparam logic [3:0]  VCS_OFS_COUNT     = 4'h4;   // pixel and line counters
    localparam logic [3:0]  VCS_OFS_STAT      = 4'h8;   // field flags

    // Control register field positions
    localparam int unsigned VCS_SYNC_SRC_BIT  = 19;     // sync_source_select
    localparam int unsigned VCS_FLD_METH_BIT  = 18;     // field_detect_method
    localparam int unsigned VCS_LINE_RST_BIT  = 17;     // line_counter_reset_select
    localparam int unsigned VCS_PIX_RST_BIT   = 16;     // pixel_counter_reset_select
    localparam int unsigned VCS_CAP_EN_BIT    = 15;     // capture_enable
    localparam int unsigned VCS_LONG_EN_BIT   = 12;     // long_field_detect_enable
    localparam int unsigned VCS_SHORT_EN_BIT  = 11;     // short_field_detect_enable
    localparam int unsigned VCS_RESAMPLE_BIT  = 10;     // chroma_resample_enable
    localparam int unsigned VCS_HALF_BIT      = 8;      // half horizontal scaling

    // Control reset value and writable bits; reserved 14-13 and 9 stay out
    localparam logic [31:0] VCS_CTRL_RST      = 32'h0002_0000;
    localparam logic [31:0] VCS_CTRL_WMASK    = 32'h000f_9d00;

    // Status register field positions (write one to clear the sticky flags)
    localparam int unsigned VCS_STAT_FIELD    = 0;
    localparam int unsigned VCS_STAT_LONG     = 1;
    localparam int unsigned VCS_STAT_SHORT    = 2;
    localparam int unsigned VCS_STAT_LINEACT  = 3;

    // Counter layout in the count register
    localparam int unsigned VCS_CNT_W         = 12;
    localparam int unsigned VCS_LINE_LSB      = 16;

    // Timing reference preamble and XY bit positions
    localparam logic [7:0]  VCS_TRS_ONES      = 8'hff;
    localparam logic [7:0]  VCS_TRS_ZERO      = 8'h00;
    localparam int unsigned VCS_XY_F          = 6;
    localparam int unsigned VCS_XY_V          = 5;
    localparam int unsigned VCS_XY_H          = 4;
    localparam logic [7:0]  VCS_CHROMA_MID    = 8'h80;

    // Capture mode codes; bit 1 set means raw or transport mode
    localparam logic [2:0]  VCS_MODE_BT8      = 3'h0;
    localparam logic [2:0]  VCS_MODE_YC16     = 3'h4;
    localparam int unsigned VCS_MODE_RAW_BIT  = 1;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } vcs_wb_req_t;

    // Video pins from the source
    typedef struct packed {
        logic [7:0]  data;
        logic        hctl;      // ext_horizontal_control_in
        logic        vctl;      // ext_vertical_control_in
        logic        field_id_input;       // field_id_input
    } vcs_vid_pins_t;

endpackage : vcs_pkg

// [design/vcs_sample_path.sv]
// Active-video sample path: chroma resampling and half horizontal scaling.
// Assumes bytes arrive in Cb Y Cr Y order, one per clock, while act_i is high.
`timescale 1ns/1ns
module vcs_sample_path
    import vcs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       act_i,
    input  wire logic [7:0] data_i,
    input  wire logic       resample_i,
    input  wire logic       half_i,
    output logic [7:0]      data_o,
    output logic            valid_o
);

    typedef struct packed {
        logic [1:0] phase;      // byte position inside Cb Y Cr Y
        logic       grp;        // odd sample group, dropped when halving
        logic [7:0] cb;
        logic [7:0] cr;
        logic [7:0] data;
        logic       valid;
    } vcs_path_st_t;

    vcs_path_st_t s_ff;
    vcs_path_st_t nxt_s;

    // Mean of two neighbouring chroma samples, placing it between luma sites
    function automatic logic [7:0] avg8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] sum;
        sum  = {1'b0, a} + {1'b0, b};
        avg8 = sum[8:1];
    endfunction : avg8

    // Next state of the sample path
    always_comb begin
        nxt_s       = s_ff;
        nxt_s.valid = 1'b0;
        if (!act_i) begin
            nxt_s.phase = 2'h0;
            nxt_s.grp   = 1'b0;
            nxt_s.cb    = VCS_CHROMA_MID;   // Neutral start avoids a colour edge
            nxt_s.cr    = VCS_CHROMA_MID;
        end else begin
            nxt_s.phase = s_ff.phase + 2'h1;
            if (s_ff.phase == 2'h3) begin
                nxt_s.grp = ~s_ff.grp;
            end
            unique case (s_ff.phase)
                2'h0: begin
                    nxt_s.data = resample_i ? avg8(s_ff.cb, data_i) : data_i;
                    nxt_s.cb   = data_i;
                end
                2'h2: begin
                    nxt_s.data = resample_i ? avg8(s_ff.cr, data_i) : data_i;
                    nxt_s.cr   = data_i;
                end
                default: begin
                    nxt_s.data = data_i;
                end
            endcase
            // Halving drops every second group; cheap, but no anti-alias filter
            nxt_s.valid = !(half_i && s_ff.grp);
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign data_o  = s_ff.data;
    assign valid_o = s_ff.valid;

    default clocking cb_clk @(posedge clk_i); endclocking
    default disable iff (rst_i);

    resample_avg_a: assert property (
        act_i && resample_i && s_ff.phase == 2'h0
        |=> data_o == avg8($past(s_ff.cb), $past(data_i)))
        else $error("resampled chroma is not the neighbour mean");
    resample_off_a: assert property (
        act_i && !resample_i && !half_i |=> valid_o && data_o == $past(data_i))
        else $error("sample altered with resampling off");
    half_drop_a: assert property (
        act_i && half_i && s_ff.grp |=> !valid_o)
        else $error("odd group passed while halving");
    resample_c: cover property (act_i && resample_i ##1 act_i [*4]);

endmodule : vcs_sample_path

// [design/vcs_sync_ctrl.sv]
// Capture sync control: control register, timing decode, counters, field logic.
// Assumes video pins are asynchronous to clk_i; Wishbone master on clk_i.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module vcs_sync_ctrl
    import vcs_pkg::*;
#(
    parameter int unsigned CNT_W = VCS_CNT_W
)(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire vcs_wb_req_t       wb_req_i,
    output logic                   wb_ack_o,
    output logic [31:0]            wb_dat_o,
    input  wire vcs_vid_pins_t     vid_i,
    input  wire logic [2:0]        capture_mode_i,
    output logic [CNT_W-1:0]       pixel_counter_o,
    output logic [CNT_W-1:0]       line_counter_o,
    output logic                   field_o,
    output logic                   long_field_o,
    output logic                   short_field_o,
    output logic [7:0]             cap_data_o,
    output logic                   cap_valid_o
);

    typedef struct packed {
        vcs_vid_pins_t   p1;        // First synchroniser stage
        vcs_vid_pins_t   p2;        // Second synchroniser stage
        logic            hctl_q;
        logic            vctl_q;
        logic [7:0]      h1;        // Byte history, newest first
        logic [7:0]      h2;
        logic [7:0]      h3;
        logic            v_bit;     // V flag of the last EAV
        logic            h_act;     // Between SAV and EAV
        logic [CNT_W-1:0] pix;
        logic [CNT_W-1:0] line;
        logic [CNT_W-1:0] line_len;
        logic [CNT_W-1:0] prev1;
        logic [CNT_W-1:0] prev2;
        logic [1:0]      seen;
        logic            field;
        logic            fld_wait;
        logic            long_p;
        logic            short_p;
        logic            long_s;
        logic            short_s;
        logic [31:0]     ctrl;
        logic            ack;
        logic [31:0]     rdat;
    } vcs_main_st_t;

    vcs_main_st_t s_ff;
    vcs_main_st_t nxt_s;

    logic       trs;
    logic       eav;
    logic       sav;
    logic       embedded;
    logic       run;
    logic       ext;
    logic       h_evt;
    logic       v_evt;
    logic       req;
    logic       act;
    logic [7:0] xy;

    // Merge a write into a register under byte lanes and a writable mask
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel, input logic [31:0] msk);
        logic [31:0] m;
        m          = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & msk;
        lane_merge = (old & ~m) | (wd & m);
    endfunction : lane_merge

    // Timing code decode and event selection
    always_comb begin
        xy       = s_ff.p2.data;
        trs      = s_ff.h3 == VCS_TRS_ONES && s_ff.h2 == VCS_TRS_ZERO
                   && s_ff.h1 == VCS_TRS_ZERO;
        eav      = trs && xy[VCS_XY_H];
        sav      = trs && !xy[VCS_XY_H];
        embedded = !capture_mode_i[VCS_MODE_RAW_BIT];
        run      = s_ff.ctrl[VCS_CAP_EN_BIT] && embedded;
        ext      = s_ff.ctrl[VCS_SYNC_SRC_BIT];
        if (ext) begin
            h_evt = s_ff.ctrl[VCS_PIX_RST_BIT] ? (!s_ff.p2.hctl && s_ff.hctl_q)
                                               : (s_ff.p2.hctl && !s_ff.hctl_q);
            v_evt = s_ff.ctrl[VCS_LINE_RST_BIT] ? (!s_ff.p2.vctl && s_ff.vctl_q)
                                                : (s_ff.p2.vctl && !s_ff.vctl_q);
        end else begin
            h_evt = s_ff.ctrl[VCS_PIX_RST_BIT] ? sav : eav;
            v_evt = eav && (s_ff.ctrl[VCS_LINE_RST_BIT] ? (!xy[VCS_XY_V] && s_ff.v_bit)
                                                        : (xy[VCS_XY_V] && !s_ff.v_bit));
        end
        // 0xff never occurs as active data, so it also marks a preamble start
        act = run && (ext ? !s_ff.p2.hctl : s_ff.h_act) && xy != VCS_TRS_ONES;
        req = wb_req_i.cyc && wb_req_i.stb;
    end

    // Next state: pins, counters, field logic and register file
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.p1      = vid_i;
        nxt_s.p2      = s_ff.p1;
        nxt_s.hctl_q  = s_ff.p2.hctl;
        nxt_s.vctl_q  = s_ff.p2.vctl;
        nxt_s.h1      = s_ff.p2.data;
        nxt_s.h2      = s_ff.h1;
        nxt_s.h3      = s_ff.h2;
        nxt_s.long_p  = 1'b0;
        nxt_s.short_p = 1'b0;
        if (eav) begin
            nxt_s.v_bit = xy[VCS_XY_V];
        end
        if (sav) begin
            nxt_s.h_act = 1'b1;
        end else if (eav || xy == VCS_TRS_ONES) begin
            nxt_s.h_act = 1'b0;
        end
        if (!run) begin
            // Counters park while disabled or in raw and transport modes
            nxt_s.pix      = '0;
            nxt_s.line     = '0;
            nxt_s.seen     = 2'h0;
            nxt_s.fld_wait = 1'b0;
        end else begin
            nxt_s.pix = h_evt ? '0 : s_ff.pix + 1'b1;
            if (h_evt) begin
                nxt_s.line_len = s_ff.pix;
            end
            if (v_evt) begin
                nxt_s.line = CNT_W'(1);
            end else if (h_evt) begin
                nxt_s.line = s_ff.line + 1'b1;
            end
            // Field identification
            if (s_ff.ctrl[VCS_FLD_METH_BIT]) begin
                if (v_evt) begin
                    nxt_s.field = s_ff.pix >= (s_ff.line_len >> 1);
                end
            end else if (ext) begin
                if (v_evt) begin
                    nxt_s.field = s_ff.p2.field_id_input;
                end
            end else begin
                if (eav && s_ff.fld_wait) begin
                    nxt_s.field    = xy[VCS_XY_F];
                    nxt_s.fld_wait = 1'b0;
                end
                if (v_evt) begin
                    nxt_s.fld_wait = 1'b1;
                end
            end
            // Compare with the same-parity field two vertical events back
            if (v_evt) begin
                nxt_s.prev1 = s_ff.line;
                nxt_s.prev2 = s_ff.prev1;
                if (s_ff.seen != 2'h3) begin
                    nxt_s.seen = s_ff.seen + 2'h1;
                end
                if (s_ff.seen == 2'h3) begin
                    nxt_s.long_p  = s_ff.ctrl[VCS_LONG_EN_BIT]
                                    && s_ff.line > s_ff.prev2;
                    nxt_s.short_p = s_ff.ctrl[VCS_SHORT_EN_BIT]
                                    && s_ff.line < s_ff.prev2;
                end
            end
        end
        // Register slave: ack one cycle after the request, write on the ack edge
        nxt_s.ack = req && !s_ff.ack;
        if (req && !s_ff.ack && !wb_req_i.we) begin
            unique case (wb_req_i.adr)
                VCS_OFS_CTRL:  nxt_s.rdat = s_ff.ctrl & VCS_CTRL_WMASK;
                VCS_OFS_COUNT: nxt_s.rdat = {{(32-VCS_LINE_LSB-CNT_W){1'b0}}, s_ff.line,
                                             {(VCS_LINE_LSB-CNT_W){1'b0}}, s_ff.pix};
                VCS_OFS_STAT:  nxt_s.rdat = {28'h0, s_ff.h_act, s_ff.short_s,
                                             s_ff.long_s, s_ff.field};
                default:       nxt_s.rdat = 32'h0;
            endcase
        end
        if (req && s_ff.ack && wb_req_i.we) begin
            if (wb_req_i.adr == VCS_OFS_CTRL) begin
                nxt_s.ctrl = lane_merge(s_ff.ctrl, wb_req_i.dat, wb_req_i.sel,
                                        VCS_CTRL_WMASK);
            end
            if (wb_req_i.adr == VCS_OFS_STAT && wb_req_i.sel[0]) begin
                if (wb_req_i.dat[VCS_STAT_LONG]) begin
                    nxt_s.long_s = 1'b0;
                end
                if (wb_req_i.dat[VCS_STAT_SHORT]) begin
                    nxt_s.short_s = 1'b0;
                end
            end
        end
        // A detection in the clearing cycle survives the clear
        if (nxt_s.long_p) begin
            nxt_s.long_s = 1'b1;
        end
        if (nxt_s.short_p) begin
            nxt_s.short_s = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff      <= '0;
            s_ff.ctrl <= VCS_CTRL_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Active video samples; resampling and scaling only in embedded modes
    vcs_sample_path u_path (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .act_i      (act),
        .data_i     (xy),
        .resample_i (s_ff.ctrl[VCS_RESAMPLE_BIT]),
        .half_i     (s_ff.ctrl[VCS_HALF_BIT]),
        .data_o     (cap_data_o),
        .valid_o    (cap_valid_o)
    );

    assign wb_ack_o        = s_ff.ack;
    assign wb_dat_o        = s_ff.rdat;
    assign pixel_counter_o = s_ff.pix;
    assign line_counter_o  = s_ff.line;
    assign field_o         = s_ff.field;
    assign long_field_o    = s_ff.long_p;
    assign short_field_o   = s_ff.short_p;

    default clocking cb_clk @(posedge clk_i); endclocking
    default disable iff (rst_i);

    pix_clear_a: assert property (run && h_evt |=> pixel_counter_o == '0)
        else $error("pixel counter not cleared by horizontal event");
    line_load_a: assert property (run && v_evt |=> line_counter_o == CNT_W'(1))
        else $error("line counter not loaded with one");
    eav_pix_a: assert property (
        run && !ext && !s_ff.ctrl[VCS_PIX_RST_BIT] && eav |=> pixel_counter_o == '0)
        else $error("EAV did not clear the pixel counter");
    ext_line_a: assert property (
        run && ext && s_ff.ctrl[VCS_LINE_RST_BIT] && !s_ff.p2.vctl && s_ff.vctl_q
        |=> line_counter_o == CNT_W'(1))
        else $error("inactive vertical edge did not load the line counter");
    emb_ignore_a: assert property (
        run && !ext && !trs && s_ff.p2.hctl && !s_ff.hctl_q
        |=> pixel_counter_o == $past(pixel_counter_o) + 1'b1)
        else $error("external line edge acted in embedded mode");
    cap_off_a: assert property (!s_ff.ctrl[VCS_CAP_EN_BIT] |=> line_counter_o == '0)
        else $error("counters ran with capture disabled");
    raw_quiet_a: assert property (
        capture_mode_i[VCS_MODE_RAW_BIT] |=> !long_field_o && !short_field_o && !cap_valid_o)
        else $error("field logic active in raw mode");
    long_gate_a: assert property (long_field_o |-> $past(s_ff.ctrl[VCS_LONG_EN_BIT]))
        else $error("long field flagged while disabled");
    short_gate_a: assert property (short_field_o |-> $past(s_ff.ctrl[VCS_SHORT_EN_BIT]))
        else $error("short field flagged while disabled");
    ext_field_a: assert property (
        run && ext && !s_ff.ctrl[VCS_FLD_METH_BIT] && v_evt |=> field_o == $past(s_ff.p2.field_id_input))
        else $error("field not taken from field input");
    // Only control reads: the count word has a live pixel bit at bit 9
    rsv_zero_a: assert property (req && !s_ff.ack && !wb_req_i.we && wb_req_i.adr == VCS_OFS_CTRL
        |=> wb_dat_o[14:13] == 2'h0 && !wb_dat_o[9])
        else $error("reserved control bits read nonzero");

    hevt_c:  cover property (run && h_evt ##1 run [*3] ##1 run && h_evt);
    long_c:  cover property (long_field_o);
    read_c:  cover property (req && !wb_req_i.we ##1 wb_ack_o);
    field_c: cover property (run && v_evt ##1 field_o);

endmodule : vcs_sync_ctrl

// [tb/vcs_vid_src.sv]
// Video source model: drives timing codes, blanking bytes and sync lines.
// Assumes the bench calls its tasks one after another on clk_i.
`timescale 1ns/1ns
module vcs_vid_src
    import vcs_pkg::*;
(
    input  wire logic    clk_i,
    output vcs_vid_pins_t pins_o
);
    // Idle pins: blanking luma level, sync lines inactive
    initial pins_o = '{data: 8'h10, hctl: 1'b0, vctl: 1'b0, field_id_input: 1'b0};

    // F flag carried by every timing code; the bench sets it
    logic f_bit = 1'b0;

    // One byte per clock, launched just after the rising edge
    task automatic put(input logic [7:0] b);
        @(posedge clk_i);
        pins_o.data <= b;
    endtask : put

    // Timing reference: preamble then XY with F from f_bit
    task automatic trs(input logic v, input logic h);
        put(VCS_TRS_ONES);
        put(VCS_TRS_ZERO);
        put(VCS_TRS_ZERO);
        put({1'b1, f_bit, v, h, 4'h0});
    endtask : trs

    // Alternating chroma and luma bytes; never looks like a preamble
    task automatic fill(input int n);
        for (int i = 0; i < n; i++) begin
            put(i[0] ? 8'h10 : VCS_CHROMA_MID);
        end
    endtask : fill

    // External sync levels, held long enough to pass the synchroniser
    task automatic ext(input logic h, input logic v);
        @(posedge clk_i);
        pins_o.hctl <= h;
        pins_o.vctl <= v;
        repeat (6) @(posedge clk_i);
    endtask : ext
endmodule : vcs_vid_src

// [tb/test_video_capture_sync_control.sv]
// Bench for the capture sync control block: register access and counter resets.
// Assumes the design acks each Wishbone request and the video model above.
`timescale 1ns/1ns
module test_video_capture_sync_control;
    import vcs_pkg::*;
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    vcs_wb_req_t   wb_req = '0;
    logic          wb_ack;
    logic [31:0]   wb_dat;
    vcs_vid_pins_t vid;
    logic [2:0]    mode = VCS_MODE_BT8;
    logic [11:0]   pix;
    logic [11:0]   line;
    logic [31:0]   rd;
    logic          vb;
    logic          fld;
    logic          lng;
    logic          sht;
    logic          cval;
    logic [7:0]    cdat;
    logic [31:0]   hist = 32'h0;
    int            n_long = 0;
    int            n_short = 0;
    int            n_valid = 0;
    int            base;
    int            error_cnt = 0;
    int            num_checks = 0;

    always #5 clk_i = ~clk_i;

    vcs_vid_src src_u (.clk_i(clk_i), .pins_o(vid));
    vcs_sync_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_ack_o(wb_ack),
        .wb_dat_o(wb_dat), .vid_i(vid), .capture_mode_i(mode), .pixel_counter_o(pix),
        .line_counter_o(line), .field_o(fld), .long_field_o(lng), .short_field_o(sht),
        .cap_data_o(cdat), .cap_valid_o(cval));

    // Pulse and sample monitors; one-cycle outputs are only seen by watching every edge
    always @(posedge clk_i) begin
        if (lng === 1'b1) n_long <= n_long + 1;
        if (sht === 1'b1) n_short <= n_short + 1;
        if (cval === 1'b1) begin
            n_valid <= n_valid + 1;
            hist    <= {hist[23:0], cdat};
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) check(1'b0, 1'b1, "bus ack timeout");
        rd = wb_dat;
        wb_req <= '0;
    endtask : wb

    // Fields are set with capture off, then capture is switched on
    task automatic cfg(input logic [31:0] v);
        wb(1'b1, VCS_OFS_CTRL, 32'h0);
        wb(1'b1, VCS_OFS_CTRL, v);
        wb(1'b1, VCS_OFS_CTRL, v | 32'h0000_8000);
    endtask : cfg

    // Counters move a few clocks after the pins, so allow a short bounded wait
    task automatic wline(input logic [11:0] e, input string msg);
        for (int i = 0; i < 10 && line !== e; i++) @(posedge clk_i);
        check(line, e, msg);
    endtask : wline

    task automatic wpix0(input string msg);
        for (int i = 0; i < 10 && pix !== 12'h0; i++) @(posedge clk_i);
        check(pix, 12'h0, msg);
    endtask : wpix0

    task automatic eav(input logic v);
        src_u.trs(v, 1'b1);
        src_u.fill(6);
    endtask : eav

    initial begin
        #200000;
        $display("Error at %0t: watchdog expired", $time);
        error_cnt++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, VCS_OFS_CTRL, 32'h0);
        check(rd, VCS_CTRL_RST, "control reset value");
        // Reserved bits stay zero; capture bit kept clear on purpose
        wb(1'b1, VCS_OFS_CTRL, 32'hffff_7fff);
        wb(1'b0, VCS_OFS_CTRL, 32'h0);
        check(rd, 32'h000f_1d00, "control readback");
        wb(1'b1, 4'hc, 32'hffff_ffff);
        wb(1'b0, 4'hc, 32'h0);
        check(rd, 32'h0, "unmapped read");
        // Capture off: codes must not move the counters
        wb(1'b1, VCS_OFS_CTRL, 32'h0002_0000);
        eav(1'b1);
        eav(1'b0);
        eav(1'b0);
        check(line, 12'h0, "line while disabled");
        // Vertical event at blanking end, then at blanking start
        for (int s = 0; s < 2; s++) begin
            vb = s[0];
            cfg(s ? 32'h0 : 32'h0002_0000);
            eav(~vb);
            eav(~vb);
            wline(12'h2, "line counts");
            eav(vb);
            wline(12'h1, "vertical load");
            eav(vb);
            wline(12'h2, "line after load");
        end
        // Pixel reset on EAV then on SAV; the other code must not clear it
        for (int p = 0; p < 2; p++) begin
            cfg(p ? 32'h0003_0000 : 32'h0002_0000);
            src_u.trs(1'b0, p == 0);
            src_u.fill(20);
            check(pix != 12'h0, 1'b1, "pixel counting");
            src_u.ext(1'b1, 1'b0);
            src_u.ext(1'b0, 1'b0);
            src_u.trs(1'b0, p != 0);
            src_u.fill(6);
            check(pix != 12'h0, 1'b1, "unselected code");
            src_u.trs(1'b0, p == 0);
            wpix0("pixel reset");
        end
        // External lines: codes ignored, line edges count and load
        cfg(32'h000a_0000);
        src_u.ext(1'b1, 1'b0);
        src_u.ext(1'b0, 1'b0);
        src_u.ext(1'b1, 1'b0);
        src_u.ext(1'b0, 1'b0);
        wline(12'h2, "external horizontal");
        eav(1'b1);
        eav(1'b0);
        check(line, 12'h2, "codes ignored");
        src_u.ext(1'b0, 1'b1);
        src_u.ext(1'b0, 1'b0);
        wline(12'h1, "external vertical");
        // Raw mode parks the counters at zero
        wb(1'b1, VCS_OFS_CTRL, 32'h0);
        mode <= 3'h2;
        cfg(32'h0002_0000);
        eav(1'b1);
        eav(1'b0);
        eav(1'b0);
        check(line, 12'h0, "raw mode line");
        // Field flag from the EAV after the vertical event; field lengths 2,3,3,2 lines
        wb(1'b1, VCS_OFS_CTRL, 32'h0);
        mode <= VCS_MODE_BT8;
        src_u.f_bit = 1'b1;
        cfg(32'h0002_1800);
        for (int f = 0; f < 5; f++) begin
            eav(1'b1);
            eav(1'b0);
            if (f == 1 || f == 2) eav(1'b0);
        end
        check(fld, 1'b1, "field flag");
        check(n_long, 1, "long field pulses");
        check(n_short, 1, "short field pulses");
        wb(1'b0, VCS_OFS_STAT, 32'h0);
        check(rd, 32'h7, "field status");
        wb(1'b1, VCS_OFS_STAT, 32'h6);
        wb(1'b0, VCS_OFS_STAT, 32'h0);
        check(rd, 32'h1, "status clear");
        // One active line of Cb Y Cr Y bytes, resampled, then halved
        for (int h = 0; h < 2; h++) begin
            cfg(h ? 32'h0002_0100 : 32'h0002_0400);
            base = n_valid;
            src_u.trs(1'b0, 1'b0);
            for (int i = 0; i < 8; i++) src_u.put(8'(64'h4020_6020_c020_a020 >> (56 - 8 * i)));
            eav(1'b0);
            check(n_valid - base, h ? 4 : 8, "valid samples");
            check(hist, h ? 32'h4020_6020 : 32'h8020_8020, "captured samples");
        end
        test_done();
    end
endmodule : test_video_capture_sync_control
